// *** pkg/ccu_pkg.sv ***
// Functional notes
// - Compare value continuously checked against timer count
// - Match performs mode-selected pin action
// - Event flag sets with the pin action
// - Every match can interrupt and trigger conversion
// - Two clearing modes reset timer on match
// - Capture mode change may set flag falsely
// - Timer ticks on instruction clock or external
// - Instruction-clocked timer holds during sleep
// - Capture runs in sleep if clock runs
`default_nettype none
package ccu_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STAT_OFS     = 12'h004;
  localparam logic [11:0] CMPV_OFS     = 12'h008;
  localparam logic [11:0] TIMR_OFS     = 12'h00C;
  localparam int          STAT_FLAG_BIT = 0;
  localparam int          STAT_OUT_BIT  = 1;
  localparam logic [15:0] TIMER_RST    = 16'h0000;
  localparam logic [15:0] CMPV_RST     = 16'h0000;

  // ------------------------------------------------------------
  // Mode codes
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR    = 4'h1;
  localparam logic [3:0] MODE_TOG        = 4'h2;
  localparam logic [3:0] MODE_CAP_ANY    = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_SET        = 4'h8;
  localparam logic [3:0] MODE_CLR        = 4'h9;
  localparam logic [3:0] MODE_PULSE      = 4'hA;
  localparam logic [3:0] MODE_PULSE_CLR  = 4'hB;

  // Instruction clock is the oscillator divided by this
  localparam int         INSTR_DIV = 4;
  localparam logic [1:0] PRESC_MAX = 2'(INSTR_DIV - 1);

  typedef enum logic {SRC_INSTR, SRC_EXT} src_t;

  typedef struct packed {
    logic       unit_event_enable;
    logic       adc_sel;
    src_t       timer_src;
    logic       en;
    logic [3:0] mode;
  } ctrl_t;

  localparam logic [7:0] CTRL_RST = 8'h00;

  function automatic logic is_compare(input logic [3:0] m);
    return (m == MODE_TOG_CLR) || (m == MODE_TOG) || (m == MODE_SET) ||
           (m == MODE_CLR) || (m == MODE_PULSE) || (m == MODE_PULSE_CLR);
  endfunction

  function automatic logic is_capture(input logic [3:0] m);
    return (m == MODE_CAP_ANY) || (m == MODE_CAP_FALL) ||
           (m == MODE_CAP_RISE);
  endfunction

  function automatic logic is_pulse(input logic [3:0] m);
    return (m == MODE_PULSE) || (m == MODE_PULSE_CLR);
  endfunction

  function automatic logic clears_timer(input logic [3:0] m);
    return (m == MODE_TOG_CLR) || (m == MODE_PULSE_CLR);
  endfunction

endpackage
`default_nettype wire

// *** rtl/capture_compare_unit.sv ***
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_clk_in,
  input  wire logic        sleep_in,
  input  wire logic        capture_in,
  output logic             unit_waveform_output,
  output logic             adc_trigger,
  output logic             unit_event_request
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  ccu_pkg::ctrl_t ctrl_q;
  ccu_pkg::ctrl_t ctrl_new;
  logic [15:0]    timer_q;
  logic [15:0]    timer_d;
  logic [15:0]    cmp_q;
  logic [15:0]    cmp_d;
  logic [1:0]     presc_q;
  logic           ext_prev_q;
  logic           cap_prev_q;
  logic           eq_q;
  logic           flag_q;
  logic           wave_q;
  logic           adc_q;
  logic [31:0]    rdata_q;

  wire       acc      = psel && penable;
  wire       setup    = psel && !penable;
  wire       hit_ctrl = (paddr == ccu_pkg::CTRL_OFS);
  wire       hit_stat = (paddr == ccu_pkg::STAT_OFS);
  wire       hit_cmpv = (paddr == ccu_pkg::CMPV_OFS);
  wire       hit_timr = (paddr == ccu_pkg::TIMR_OFS);
  wire       hit_any  = hit_ctrl || hit_stat || hit_cmpv || hit_timr;
  wire       wr       = acc && pwrite;
  wire       ctrl_wr  = wr && hit_ctrl;
  wire       cmp_wr   = wr && hit_cmpv;
  wire       tmr_wr   = wr && hit_timr;
  wire       flag_clr = wr && hit_stat && pwdata[ccu_pkg::STAT_FLAG_BIT];
  wire [3:0] mode     = ctrl_q.mode;

  assign ctrl_new = ccu_pkg::ctrl_t'(pwdata[7:0]);

  wire [31:0] rsel =
    hit_ctrl ? {24'h00_0000, ctrl_q} :
    hit_stat ? {30'h0000_0000, wave_q, flag_q} :
    hit_cmpv ? {16'h0000, cmp_q} :
    hit_timr ? {16'h0000, timer_q} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;
  assign prdata  = rdata_q;

  // ------------------------------------------------------------
  // Timer tick source
  // ------------------------------------------------------------
  wire ext_rise   = ext_clk_in && !ext_prev_q;
  wire instr_tick = (presc_q == ccu_pkg::PRESC_MAX);
  wire tick = ctrl_q.en && ((ctrl_q.timer_src == ccu_pkg::SRC_EXT) ?
              ext_rise : (instr_tick && !sleep_in));

  // ------------------------------------------------------------
  // Compare and capture events
  // ------------------------------------------------------------
  wire eq = (cmp_q == timer_q);
  wire match = ctrl_q.en && ccu_pkg::is_compare(mode) && eq && !eq_q;
  wire cap_rise = capture_in && !cap_prev_q;
  wire cap_fall = !capture_in && cap_prev_q;
  wire cap_evt  = ctrl_q.en && (
    ((mode == ccu_pkg::MODE_CAP_ANY)  && (cap_rise || cap_fall)) ||
    ((mode == ccu_pkg::MODE_CAP_FALL) && cap_fall) ||
    ((mode == ccu_pkg::MODE_CAP_RISE) && cap_rise));
  // capture mode change raises false event
  wire mode_chg = ctrl_wr && (ctrl_new.mode != mode) &&
    (ccu_pkg::is_capture(mode) || ccu_pkg::is_capture(ctrl_new.mode));

  assign timer_d = tmr_wr ? pwdata[15:0] :
    (match && ccu_pkg::clears_timer(mode)) ? ccu_pkg::TIMER_RST :
    tick ? 16'(timer_q + 16'h0001) : timer_q;

  assign cmp_d = cap_evt ? timer_q : cmp_wr ? pwdata[15:0] : cmp_q;

  wire flag_d = (flag_q && !flag_clr) || match || cap_evt || mode_chg;

  function automatic logic wave_next(input logic [3:0] m, input logic w);
    case (m)
      ccu_pkg::MODE_TOG_CLR,
      ccu_pkg::MODE_TOG:       wave_next = !w;
      ccu_pkg::MODE_SET,
      ccu_pkg::MODE_PULSE,
      ccu_pkg::MODE_PULSE_CLR: wave_next = 1'b1;
      ccu_pkg::MODE_CLR:       wave_next = 1'b0;
      default:                 wave_next = w;
    endcase
  endfunction

  wire wave_d = match ? wave_next(mode, wave_q) :
                ccu_pkg::is_pulse(mode) ? 1'b0 : wave_q;

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q     <= ccu_pkg::ctrl_t'(ccu_pkg::CTRL_RST);
      timer_q    <= ccu_pkg::TIMER_RST;
      cmp_q      <= ccu_pkg::CMPV_RST;
      presc_q    <= 2'h0;
      ext_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
      eq_q       <= 1'b0;
      flag_q     <= 1'b0;
      wave_q     <= 1'b0;
      adc_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_new;
      end
      if (!sleep_in) begin
        presc_q <= 2'(presc_q + 2'h1);
      end
      if (setup && !pwrite) begin
        rdata_q <= rsel;
      end
      timer_q    <= timer_d;
      cmp_q      <= cmp_d;
      ext_prev_q <= ext_clk_in;
      cap_prev_q <= capture_in;
      eq_q       <= eq;
      flag_q     <= flag_d;
      wave_q     <= wave_d;
      adc_q      <= match && ctrl_q.adc_sel;
    end
  end

  assign unit_waveform_output = wave_q;
  assign adc_trigger          = adc_q;
  assign unit_event_request   = flag_q && ctrl_q.unit_event_enable;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_match_eq;
    @(posedge clk) disable iff (!rst_sync_q)
    match |-> (cmp_q == timer_q) && !$past(eq);
  endproperty
  a_match_eq: assert property (p_match_eq)
    else $error("match without fresh equality");

  property p_toggle;
    @(posedge clk) disable iff (!rst_sync_q)
    match && (mode == ccu_pkg::MODE_TOG) |=> wave_q != $past(wave_q);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle mode did not toggle");

  property p_pulse;
    @(posedge clk) disable iff (!rst_sync_q)
    match && ccu_pkg::is_pulse(mode) |=> wave_q ##1 (!wave_q || match);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse not one cycle");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_sync_q)
    match |=> flag_q && (wave_q == wave_next($past(mode), $past(wave_q)));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set with pin action");

  property p_adc;
    @(posedge clk) disable iff (!rst_sync_q)
    match && ctrl_q.adc_sel |=> adc_trigger ##1 !adc_trigger || $past(match);
  endproperty
  a_adc: assert property (p_adc)
    else $error("conversion trigger missing");

  property p_clr_tmr;
    @(posedge clk) disable iff (!rst_sync_q)
    match && ccu_pkg::clears_timer(mode) && !tmr_wr |=> timer_q == 16'h0000;
  endproperty
  a_clr_tmr: assert property (p_clr_tmr)
    else $error("timer not cleared on match");

  property p_spur;
    @(posedge clk) disable iff (!rst_sync_q)
    mode_chg |=> flag_q;
  endproperty
  a_spur: assert property (p_spur)
    else $error("mode change event lost");

  property p_sleep_hold;
    @(posedge clk) disable iff (!rst_sync_q)
    sleep_in && (ctrl_q.timer_src == ccu_pkg::SRC_INSTR) && !tmr_wr &&
    !match |=> $stable(timer_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("timer moved in sleep");

  property p_ext_run;
    @(posedge clk) disable iff (!rst_sync_q)
    ctrl_q.en && (ctrl_q.timer_src == ccu_pkg::SRC_EXT) && ext_rise &&
    !tmr_wr && !match |=> timer_q == 16'($past(timer_q) + 16'h0001);
  endproperty
  a_ext_run: assert property (p_ext_run)
    else $error("external tick not counted");

  property p_capture;
    @(posedge clk) disable iff (!rst_sync_q)
    cap_evt |=> (cmp_q == $past(timer_q)) && flag_q;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag wrong");

  property p_sticky;
    @(posedge clk) disable iff (!rst_sync_q)
    flag_q && !flag_clr |=> flag_q;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

endmodule
`default_nettype wire

// *** test/ccu_far_side.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccu_far_side (
  input  wire logic clk,
  input  wire logic ext_go,
  input  wire logic cap_go,
  input  wire logic adc_trigger,
  input  wire logic unit_waveform_output,
  output logic      ext_clk_in,
  output logic      capture_in,
  output var int    adc_count,
  output var int    pin_rises
);
  logic pin_prev = 1'b0;
  logic ext_q    = 1'b0;
  logic cap_q    = 1'b0;
  int   adc_n    = 0;
  int   rise_n   = 0;
  assign ext_clk_in = ext_q;
  assign capture_in = cap_q;
  assign adc_count  = adc_n;
  assign pin_rises  = rise_n;
  always @(posedge clk) begin
    ext_q <= ext_go;
    if (cap_go) begin
      cap_q <= ~cap_q;
    end
  end
  always @(posedge clk) begin
    pin_prev <= unit_waveform_output;
    if (adc_trigger === 1'b1) begin
      adc_n <= adc_n + 1;
    end
    if (unit_waveform_output === 1'b1 && pin_prev === 1'b0) begin
      rise_n <= rise_n + 1;
    end
  end
endmodule
`default_nettype wire

// *** test/capture_compare_unit_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module capture_compare_unit_tb;
  logic        clk, rst_n, psel, penable, pwrite, sleep_in, ext_go, cap_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, last_err, ext_clk_in, capture_in, p;
  logic        unit_waveform_output, adc_trigger, unit_event_request;
  int          adc_count, pin_rises, errors, samples_checked, seed, n, a0, r0;
  logic [15:0] cmp, tv;
  logic [3:0]  modes [6] = '{ccu_pkg::MODE_TOG_CLR, ccu_pkg::MODE_TOG,
    ccu_pkg::MODE_SET, ccu_pkg::MODE_CLR, ccu_pkg::MODE_PULSE,
    ccu_pkg::MODE_PULSE_CLR};

  capture_compare_unit capture_compare_unit_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .sleep_in(sleep_in), .capture_in(capture_in),
    .unit_waveform_output(unit_waveform_output), .adc_trigger(adc_trigger),
    .unit_event_request(unit_event_request));
  ccu_far_side ccu_far_side_i (.clk(clk), .ext_go(ext_go), .cap_go(cap_go),
    .adc_trigger(adc_trigger), .unit_waveform_output(unit_waveform_output),
    .ext_clk_in(ext_clk_in), .capture_in(capture_in),
    .adc_count(adc_count), .pin_rises(pin_rises));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_word(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic ok, input string what);
    chk_word({31'h0, ok}, 32'h0000_0001, what);
  endtask

  task automatic ext_pulse();
    ext_go <= 1'b1;
    repeat (2) @(posedge clk);
    ext_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic cap_pulse();
    cap_go <= 1'b1;
    @(posedge clk);
    cap_go <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic wait_event();
    n = 0;
    while (unit_event_request !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask

  function automatic logic pin_after(input logic [3:0] m, input logic q);
    if (m == ccu_pkg::MODE_TOG_CLR || m == ccu_pkg::MODE_TOG) begin
      return ~q;
    end
    return m == ccu_pkg::MODE_SET;
  endfunction

  function automatic logic [31:0] timer_after(input logic [3:0] m);
    if (m == ccu_pkg::MODE_TOG_CLR || m == ccu_pkg::MODE_PULSE_CLR) begin
      return 32'h0000_0000;
    end
    return {16'h0000, cmp};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, sleep_in, ext_go, cap_go} = 7'h00;
    {paddr, pwdata} = 44'h0;
    {errors, samples_checked, seed} = {32'd0, 32'd0, 32'd69};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk_word(rd, 32'h0000_0000, "reset value");
    end
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(last_err, "unmapped error");
    chk_word(rd, 32'h0000_0000, "unmapped data");
    $display("test reset done");
    foreach (modes[i]) begin
      cmp = 16'($random(seed)) | 16'h0010;
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, ccu_pkg::TIMR_OFS, {16'h0, cmp - 16'h0001});
      apb(1'b1, ccu_pkg::CMPV_OFS, {16'h0, cmp});
      apb(1'b1, ccu_pkg::CTRL_OFS, {24'h0, 4'hF, modes[i]});
      apb(1'b1, ccu_pkg::STAT_OFS, 32'h1);
      apb(1'b0, ccu_pkg::STAT_OFS, 32'h0);
      p  = rd[1];
      a0 = adc_count;
      r0 = pin_rises;
      ext_pulse();
      wait_event();
      chk_bit(unit_event_request, "event request");
      apb(1'b0, ccu_pkg::STAT_OFS, 32'h0);
      chk_word(rd, {30'h0, pin_after(modes[i], p), 1'b1}, "pin");
      apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
      chk_word(rd, timer_after(modes[i]), "timer");
      chk_word(32'(adc_count - a0), 32'h1, "adc");
      if (modes[i] == ccu_pkg::MODE_PULSE ||
          modes[i] == ccu_pkg::MODE_PULSE_CLR) begin
        chk_word(32'(pin_rises - r0), 32'h1, "pulse");
      end
    end
    $display("test compare done");
    tv = 16'($random(seed)) & 16'h7FFF;
    apb(1'b1, ccu_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, ccu_pkg::TIMR_OFS, {16'h0, tv});
    apb(1'b1, ccu_pkg::CTRL_OFS, {24'h0, 4'hB, ccu_pkg::MODE_CAP_ANY});
    apb(1'b1, ccu_pkg::STAT_OFS, 32'h1);
    cap_pulse();
    wait_event();
    apb(1'b0, ccu_pkg::CMPV_OFS, 32'h0);
    chk_word(rd, {16'h0, tv}, "capture");
    sleep_in <= 1'b1;
    ext_pulse();
    cap_pulse();
    apb(1'b0, ccu_pkg::CMPV_OFS, 32'h0);
    chk_word(rd, {16'h0, tv + 16'h0001}, "sleep capture");
    apb(1'b0, ccu_pkg::STAT_OFS, 32'h0);
    chk_bit(rd[0], "flag sticky");
    sleep_in <= 1'b0;
    $display("test capture done");
    apb(1'b1, ccu_pkg::CTRL_OFS, 32'h0000_0010);
    apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
    tv = rd[15:0];
    repeat (40) @(posedge clk);
    apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
    chk_bit((rd[15:0] - tv) inside {16'd10, 16'd11}, "tick rate");
    sleep_in <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
    tv = rd[15:0];
    repeat (40) @(posedge clk);
    apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
    chk_word(rd, {16'h0, tv}, "sleep hold");
    sleep_in <= 1'b0;
    repeat (40) @(posedge clk);
    apb(1'b0, ccu_pkg::TIMR_OFS, 32'h0);
    tv = 16'(tv + 16'(40 / ccu_pkg::INSTR_DIV));
    chk_word(rd, {16'h0000, tv}, "resume");
    $display("test sleep done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
